//--- i2c_mux_params.svh
// Constants shared by both ends of the mux control link.
// Assumes it is included by bare name from the device and master modules.
`ifndef I2C_MUX_PARAMS_SVH
`define I2C_MUX_PARAMS_SVH

`define CTRL_RESET 8'h00
`define CTRL_STORED_MSB 3
`define SEL_MSB 2
`define SEL_ENABLE_BIT 2
`define SEL_GUARD_BIT 1
`define SEL_LANE_BIT 0
`define RW_READ 1'b1
`define BITS_PER_BYTE 4'h8
`define ADDR_FIXED_DEFAULT 4'h5
`define CORE_CLK_PERIOD_NS 20
`define SCL_PERIOD_NS 10000
`define SCL_QUARTER_CYC ((`SCL_PERIOD_NS) / (4 * `CORE_CLK_PERIOD_NS))

`endif

//--- i2c_mux_pkg.sv
// Types shared by both ends of the mux control link.
// Assumes the constants header is on the include path.
package i2c_mux_pkg;
  typedef enum logic [7:0] {
    DEV_IDLE = 8'h01,
    DEV_ADDR = 8'h02,
    DEV_ADDR_ACK = 8'h04,
    DEV_WRITE = 8'h08,
    DEV_WRITE_ACK = 8'h10,
    DEV_READ = 8'h20,
    DEV_READ_ACK = 8'h40,
    DEV_IGNORE = 8'h80
  } dev_state_t;

  typedef enum logic [4:0] {
    MST_IDLE = 5'h01,
    MST_WAIT_BUS = 5'h02,
    MST_START = 5'h04,
    MST_BIT = 5'h08,
    MST_STOP = 5'h10
  } mst_state_t;
endpackage

//--- i2c_mux_link.sv
// Open-drain SCL and SDA wires between the bus master and the mux device.
// Assumes pull-ups: a line reads high unless some party enables its driver.
`timescale 1ns/10ps
interface i2c_mux_link;
  logic scl_oe_m;
  logic sda_oe_m;
  logic sda_oe_d;
  logic scl;
  logic sda;

  assign scl = ~scl_oe_m;
  assign sda = ~(sda_oe_m | sda_oe_d);

  modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
  modport device (output sda_oe_d, input scl, input sda);
endinterface

//--- i2c_mux_device.sv
// Mux control slave: control register, channel select and alert combining.
// Assumes SCL and SDA arrive asynchronously and are oversampled by i_core_clk.
`timescale 1ns/10ps
`include "i2c_mux_params.svh"
module i2c_mux_device #(
  parameter logic [3:0] ADDR_FIXED = `ADDR_FIXED_DEFAULT
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  i2c_mux_link.device bus,
  input wire logic [2:0] i_addr_pin,
  input wire logic i_lane0_alert_in_n,
  input wire logic i_lane1_alert_in_n,
  output logic o_alert_oe,
  output logic o_down0_connect,
  output logic o_down1_connect
);
  localparam int PINS = 7;

  logic [PINS-1:0] pin_meta;
  logic [PINS-1:0] pin_sync;
  logic scl_q;
  logic sda_q;
  logic scl;
  logic sda;
  logic [2:0] addr_pins;
  logic [1:0] alert_act;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  i2c_mux_pkg::dev_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] shift, next_shift;
  logic [7:0] tx, next_tx;
  logic rw, next_rw;
  logic ack_ok, next_ack_ok;
  logic sda_oe, next_sda_oe;
  logic [7:0] channel_select_control, next_channel_select_control;
  logic [1:0] conn, next_conn;
  logic alert_oe, next_alert_oe;

  // Builds the byte returned on a read from live alert levels and stored bits.
  function automatic logic [7:0] read_byte(input logic [7:0] ctrl, input logic [1:0] act);
    read_byte = {2'b00, act[1], act[0], ctrl[`CTRL_STORED_MSB:0]};
  endfunction

  // Returns {lane1, lane0} connect enables for a selection code.
  function automatic logic [1:0] decode_sel(input logic [`SEL_MSB:0] sel);
    logic on;
    on = sel[`SEL_ENABLE_BIT] & ~sel[`SEL_GUARD_BIT];
    decode_sel = {on & sel[`SEL_LANE_BIT], on & ~sel[`SEL_LANE_BIT]};
  endfunction

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      pin_meta <= '1;
      pin_sync <= '1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      pin_meta <= {i_lane1_alert_in_n, i_lane0_alert_in_n, i_addr_pin, bus.sda, bus.scl};
      pin_sync <= pin_meta;
      scl_q <= pin_sync[0];
      sda_q <= pin_sync[1];
    end
  end

  assign scl = pin_sync[0];
  assign sda = pin_sync[1];
  assign addr_pins = pin_sync[4:2];
  assign alert_act = ~pin_sync[6:5];
  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_seen = scl & scl_q & sda_q & ~sda;
  assign stop_seen = scl & scl_q & ~sda_q & sda;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_tx = tx;
    next_rw = rw;
    next_ack_ok = ack_ok;
    next_sda_oe = sda_oe;
    next_channel_select_control = channel_select_control;
    next_conn = conn;
    next_alert_oe = |alert_act;
    if (start_seen) begin
      next_state = i2c_mux_pkg::DEV_ADDR;
      next_cnt = 4'h0;
      next_shift = 8'h00;
      next_sda_oe = 1'b0;
    end else if (stop_seen) begin
      next_state = i2c_mux_pkg::DEV_IDLE;
      next_sda_oe = 1'b0;
      next_conn = decode_sel(channel_select_control[`SEL_MSB:0]);
    end else begin
      case (state)
        i2c_mux_pkg::DEV_ADDR: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == `BITS_PER_BYTE) begin
            if (shift[7:1] == {ADDR_FIXED, addr_pins}) begin
              next_rw = shift[0];
              next_sda_oe = 1'b1;
              next_state = i2c_mux_pkg::DEV_ADDR_ACK;
            end else begin
              next_state = i2c_mux_pkg::DEV_IGNORE;
            end
          end
        end
        i2c_mux_pkg::DEV_ADDR_ACK: begin
          if (scl_fall) begin
            next_cnt = 4'h0;
            next_shift = 8'h00;
            if (rw == `RW_READ) begin
              next_tx = read_byte(channel_select_control, alert_act);
              next_sda_oe = ~next_tx[7];
              next_state = i2c_mux_pkg::DEV_READ;
            end else begin
              next_sda_oe = 1'b0;
              next_state = i2c_mux_pkg::DEV_WRITE;
            end
          end
        end
        i2c_mux_pkg::DEV_WRITE: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == `BITS_PER_BYTE) begin
            next_channel_select_control = {4'h0, shift[`CTRL_STORED_MSB:0]};
            next_sda_oe = 1'b1;
            next_state = i2c_mux_pkg::DEV_WRITE_ACK;
          end
        end
        i2c_mux_pkg::DEV_WRITE_ACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_cnt = 4'h0;
            next_shift = 8'h00;
            next_state = i2c_mux_pkg::DEV_WRITE;
          end
        end
        i2c_mux_pkg::DEV_READ: begin
          if (scl_rise) begin
            next_cnt = cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == `BITS_PER_BYTE) begin
              next_sda_oe = 1'b0;
              next_state = i2c_mux_pkg::DEV_READ_ACK;
            end else begin
              next_tx = {tx[6:0], 1'b0};
              next_sda_oe = ~tx[6];
            end
          end
        end
        i2c_mux_pkg::DEV_READ_ACK: begin
          if (scl_rise) begin
            next_ack_ok = ~sda;
          end else if (scl_fall) begin
            if (ack_ok) begin
              next_tx = read_byte(channel_select_control, alert_act);
              next_sda_oe = ~next_tx[7];
              next_cnt = 4'h0;
              next_state = i2c_mux_pkg::DEV_READ;
            end else begin
              next_state = i2c_mux_pkg::DEV_IGNORE;
            end
          end
        end
        default: begin
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state <= i2c_mux_pkg::DEV_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      ack_ok <= 1'b0;
      sda_oe <= 1'b0;
      channel_select_control <= `CTRL_RESET;
      conn <= 2'b00;
      alert_oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      tx <= next_tx;
      rw <= next_rw;
      ack_ok <= next_ack_ok;
      sda_oe <= next_sda_oe;
      channel_select_control <= next_channel_select_control;
      conn <= next_conn;
      alert_oe <= next_alert_oe;
    end
  end

  assign bus.sda_oe_d = sda_oe;
  assign o_alert_oe = alert_oe;
  assign o_down0_connect = conn[0];
  assign o_down1_connect = conn[1];
endmodule

//--- i2c_mux_master.sv
// Bus master end: runs single transactions of one or more bytes on the link.
// Assumes the user holds a command stable while it is offered with i_cmd_valid.
`timescale 1ns/10ps
`include "i2c_mux_params.svh"
module i2c_mux_master #(
  parameter int QUARTER_CYCLES = `SCL_QUARTER_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  i2c_mux_link.master bus,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_read,
  input wire logic [6:0] i_cmd_addr,
  input wire logic [3:0] i_cmd_len,
  input wire logic [7:0] i_wdata,
  output logic o_cmd_ready,
  output logic o_wdata_take,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  output logic o_nack,
  output logic o_done
);
  generate
    if (QUARTER_CYCLES < 4 || QUARTER_CYCLES > 65535) begin : g_bad_quarter
      $error("QUARTER_CYCLES must lie between 4 and 65535");
    end
  endgenerate

  localparam logic [15:0] QLAST = 16'(QUARTER_CYCLES - 1);

  logic [1:0] meta;
  logic [1:0] sync;
  logic tick;
  logic sending;

  i2c_mux_pkg::mst_state_t state, next_state;
  logic [15:0] qcnt, next_qcnt;
  logic [1:0] phase, next_phase;
  logic [3:0] bitn, next_bitn;
  logic [3:0] left, next_left;
  logic is_addr, next_is_addr;
  logic rd, next_rd;
  logic [7:0] txb, next_txb;
  logic [7:0] rx, next_rx;
  logic scl_oe, next_scl_oe;
  logic sda_oe, next_sda_oe;
  logic [7:0] rdata, next_rdata;
  logic rdata_valid, next_rdata_valid;
  logic wdata_take, next_wdata_take;
  logic nack, next_nack;
  logic done, next_done;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      meta <= 2'b11;
      sync <= 2'b11;
    end else begin
      meta <= {bus.sda, bus.scl};
      sync <= meta;
    end
  end

  assign tick = (qcnt == QLAST);
  assign sending = is_addr | ~rd;

  always_comb begin
    next_state = state;
    next_qcnt = (state == i2c_mux_pkg::MST_IDLE || tick) ? 16'h0000 : qcnt + 16'h0001;
    next_phase = phase;
    next_bitn = bitn;
    next_left = left;
    next_is_addr = is_addr;
    next_rd = rd;
    next_txb = txb;
    next_rx = rx;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_rdata = rdata;
    next_rdata_valid = 1'b0;
    next_wdata_take = 1'b0;
    next_nack = nack;
    next_done = 1'b0;
    case (state)
      i2c_mux_pkg::MST_IDLE: begin
        if (i_cmd_valid) begin
          next_rd = i_cmd_read;
          next_txb = {i_cmd_addr, i_cmd_read};
          next_left = (i_cmd_len == 4'h0) ? 4'h1 : i_cmd_len;
          next_nack = 1'b0;
          next_state = i2c_mux_pkg::MST_WAIT_BUS;
        end
      end
      i2c_mux_pkg::MST_WAIT_BUS: begin
        if (sync == 2'b11) begin
          next_phase = 2'b00;
          next_qcnt = 16'h0000;
          next_state = i2c_mux_pkg::MST_START;
        end
      end
      i2c_mux_pkg::MST_START: begin
        if (tick) begin
          next_phase = phase + 2'b01;
          if (phase == 2'b00) begin
            next_sda_oe = 1'b1;
          end else if (phase == 2'b10) begin
            next_scl_oe = 1'b1;
          end else if (phase == 2'b11) begin
            next_bitn = 4'h0;
            next_is_addr = 1'b1;
            next_state = i2c_mux_pkg::MST_BIT;
          end
        end
      end
      i2c_mux_pkg::MST_BIT: begin
        if (tick) begin
          next_phase = phase + 2'b01;
          if (phase == 2'b00) begin
            if (bitn != `BITS_PER_BYTE) begin
              next_sda_oe = sending & ~txb[7];
            end else begin
              next_sda_oe = ~sending & (left != 4'h1);
            end
          end else if (phase == 2'b01) begin
            next_scl_oe = 1'b0;
          end else if (phase == 2'b11) begin
            next_scl_oe = 1'b1;
            if (bitn != `BITS_PER_BYTE) begin
              next_rx = {rx[6:0], sync[1]};
              next_txb = {txb[6:0], 1'b1};
              next_bitn = bitn + 4'h1;
            end else if (sending && sync[1]) begin
              next_nack = 1'b1;
              next_phase = 2'b00;
              next_state = i2c_mux_pkg::MST_STOP;
            end else begin
              next_bitn = 4'h0;
              next_is_addr = 1'b0;
              if (!is_addr) begin
                next_left = left - 4'h1;
              end
              if (!is_addr && rd) begin
                next_rdata = rx;
                next_rdata_valid = 1'b1;
              end
              if (!is_addr && left == 4'h1) begin
                next_phase = 2'b00;
                next_state = i2c_mux_pkg::MST_STOP;
              end else begin
                next_txb = rd ? 8'hff : i_wdata;
                next_wdata_take = ~rd;
              end
            end
          end
        end
      end
      i2c_mux_pkg::MST_STOP: begin
        if (tick) begin
          next_phase = phase + 2'b01;
          if (phase == 2'b00) begin
            next_sda_oe = 1'b1;
          end else if (phase == 2'b01) begin
            next_scl_oe = 1'b0;
          end else if (phase == 2'b10) begin
            next_sda_oe = 1'b0;
          end else begin
            next_done = 1'b1;
            next_state = i2c_mux_pkg::MST_IDLE;
          end
        end
      end
      default: begin
        next_state = i2c_mux_pkg::MST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state <= i2c_mux_pkg::MST_IDLE;
      qcnt <= 16'h0000;
      phase <= 2'b00;
      bitn <= 4'h0;
      left <= 4'h0;
      is_addr <= 1'b0;
      rd <= 1'b0;
      txb <= 8'h00;
      rx <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rdata <= 8'h00;
      rdata_valid <= 1'b0;
      wdata_take <= 1'b0;
      nack <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      qcnt <= next_qcnt;
      phase <= next_phase;
      bitn <= next_bitn;
      left <= next_left;
      is_addr <= next_is_addr;
      rd <= next_rd;
      txb <= next_txb;
      rx <= next_rx;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      rdata <= next_rdata;
      rdata_valid <= next_rdata_valid;
      wdata_take <= next_wdata_take;
      nack <= next_nack;
      done <= next_done;
    end
  end

  assign bus.scl_oe_m = scl_oe;
  assign bus.sda_oe_m = sda_oe;
  assign o_cmd_ready = (state == i2c_mux_pkg::MST_IDLE);
  assign o_wdata_take = wdata_take;
  assign o_rdata = rdata;
  assign o_rdata_valid = rdata_valid;
  assign o_nack = nack;
  assign o_done = done;
endmodule

//--- i2c_mux_link_assertions.sv
// Checker for the open-drain link between the mux master and device ends.
// Assumes it sits beside the link instance and sees its raw signals.
`timescale 1ns/10ps
module i2c_mux_link_assertions (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic scl_oe_m,
  input wire logic sda_oe_m,
  input wire logic sda_oe_d,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  AST_START_ON_IDLE: assert property ($rose(sda_oe_m) && scl |-> $past(sda))
    else $error("start begun on a busy bus");
  AST_START_CLOCKS: assert property ($rose(sda_oe_m) && scl |-> ##[1:40] !scl)
    else $error("no clock after start");
  AST_DEV_SDA_SCL_LOW: assert property ($changed(sda_oe_d) |-> !scl)
    else $error("device changed data while clock high");
  AST_DEV_ACK_HELD: assert property ($rose(scl) && sda_oe_d |-> sda_oe_d [*6])
    else $error("device low level not held through clock high");
  AST_SCL_HIGH_MIN: assert property ($fell(scl_oe_m) |-> !scl_oe_m [*4])
    else $error("clock high phase too short");
  AST_SCL_LOW_MIN: assert property ($rose(scl_oe_m) |-> scl_oe_m [*4])
    else $error("clock low phase too short");
  AST_STOP_IDLE: assert property ($fell(sda_oe_m) && scl && $past(scl) |-> scl [*4])
    else $error("bus not idle after stop");
  AST_DEV_RELEASE: assert property ($rose(sda_oe_d) |-> ##[1:400] !sda_oe_d)
    else $error("device held data line too long");
endmodule

//--- test_i2c_two_channel_mux_control.sv
// Self-checking bench: master end drives the mux device end over the link.
// Assumes both design ends and the link interface are compiled first.
`timescale 1ns/10ps
module test_i2c_two_channel_mux_control;
  localparam int Q = 6;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [2:0] addr_pin = 3'b010;
  logic alert0_n = 1'b1;
  logic alert1_n = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [3:0] cmd_len = 4'h1;
  logic [7:0] wdata = 8'h00;
  logic cmd_ready, wdata_take, rdata_valid, nack, done, alert_oe, down0, down1;
  logic [7:0] rdata;
  logic [7:0] wbuf [0:3];
  logic [7:0] rbuf [0:3];
  logic [7:0] rcount;
  logic early;
  logic last_nack;
  logic finished;
  int failures = 0;
  int comparisons = 0;

  always #10 i_core_clk = ~i_core_clk;

  i2c_mux_link link();

  i2c_mux_master #(.QUARTER_CYCLES(Q)) i_i2c_mux_master (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .bus(link), .i_cmd_valid(cmd_valid),
    .i_cmd_read(cmd_read), .i_cmd_addr(cmd_addr), .i_cmd_len(cmd_len), .i_wdata(wdata),
    .o_cmd_ready(cmd_ready), .o_wdata_take(wdata_take), .o_rdata(rdata),
    .o_rdata_valid(rdata_valid), .o_nack(nack), .o_done(done)
  );

  i2c_mux_device #(.ADDR_FIXED(4'h5)) i_i2c_mux_device (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .bus(link), .i_addr_pin(addr_pin),
    .i_lane0_alert_in_n(alert0_n), .i_lane1_alert_in_n(alert1_n), .o_alert_oe(alert_oe),
    .o_down0_connect(down0), .o_down1_connect(down1)
  );

  i2c_mux_link_assertions i_i2c_mux_link_assertions (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .scl_oe_m(link.scl_oe_m),
    .sda_oe_m(link.sda_oe_m), .sda_oe_d(link.sda_oe_d), .scl(link.scl), .sda(link.sda)
  );

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Offers one command, feeds write bytes, gathers read bytes until done.
  task automatic run_cmd(input logic rd, input logic [6:0] addr, input logic [3:0] len);
    int wi;
    int n;
    logic d0;
    logic d1;
    wi = 0;
    rcount = 8'h00;
    early = 1'b0;
    finished = 1'b0;
    d0 = down0;
    d1 = down1;
    @(negedge i_core_clk);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_addr = addr;
    cmd_len = len;
    wdata = wbuf[0];
    // The command is held until a falling edge sees ready, so the next rising edge takes it.
    for (n = 0; n < 100 && cmd_ready !== 1'b1; n++) @(negedge i_core_clk);
    for (n = 0; n < 20000 && !finished; n++) begin
      @(negedge i_core_clk);
      cmd_valid = 1'b0;
      if (wdata_take === 1'b1 && wi < 3) begin
        wi++;
        wdata = wbuf[wi];
      end
      if (rdata_valid === 1'b1) begin
        rbuf[rcount[1:0]] = rdata;
        rcount++;
      end
      if (link.scl_oe_m === 1'b1 && (down0 !== d0 || down1 !== d1)) early = 1'b1;
      if (done === 1'b1) begin
        last_nack = nack;
        finished = 1'b1;
      end
    end
    chk_bit("command done", 1'b1, finished);
    repeat (10) @(negedge i_core_clk);
  endtask

  task automatic wr(input logic [6:0] addr, input logic [7:0] b0, input logic [7:0] b1,
                    input logic [3:0] len);
    wbuf[0] = b0;
    wbuf[1] = b1;
    wbuf[2] = 8'h00;
    run_cmd(1'b0, addr, len);
  endtask

  initial begin
    #1000000;
    failures++;
    test_done();
  end

  initial begin
    logic [3:0] sel;
    logic [1:0] al;
    logic [6:0] mux_addr;
    mux_addr = {4'h5, 3'b010};
    repeat (8) @(negedge i_core_clk);
    i_srst = 1'b0;
    repeat (8) @(negedge i_core_clk);
    chk_bit("down0 after reset", 1'b0, down0);
    chk_bit("down1 after reset", 1'b0, down1);
    chk_bit("alert after reset", 1'b0, alert_oe);
    run_cmd(1'b1, mux_addr, 4'h2);
    chk_byte("read byte count", 8'h02, rcount);
    chk_byte("reset value", 8'h00, rbuf[0]);
    chk_byte("second read byte", 8'h00, rbuf[1]);
    for (int v = 0; v < 16; v++) begin
      sel = v[3:0];
      wr(mux_addr, {4'hc, sel}, 8'h00, 4'h1);
      chk_bit("write nack", 1'b0, last_nack);
      chk_bit("switch before stop", 1'b0, early);
      chk_bit("down0 select", sel[2:0] == 3'b100, down0);
      chk_bit("down1 select", sel[2:0] == 3'b101, down1);
      run_cmd(1'b1, mux_addr, 4'h1);
      chk_byte("read back", {4'h0, sel}, rbuf[0]);
    end
    wr(mux_addr, 8'h05, 8'h04, 4'h2);
    chk_bit("early switch multi", 1'b0, early);
    chk_bit("down0 last byte", 1'b1, down0);
    chk_bit("down1 last byte", 1'b0, down1);
    for (int k = 0; k < 4; k++) begin
      al = k[1:0];
      alert1_n = al[1];
      alert0_n = al[0];
      repeat (8) @(negedge i_core_clk);
      chk_bit("alert out", ~(al[1] & al[0]), alert_oe);
      run_cmd(1'b1, mux_addr, 4'h1);
      chk_byte("alert status", {2'b00, ~al[1], ~al[0], 4'h4}, rbuf[0]);
      chk_bit("down0 during alert", 1'b1, down0);
    end
    alert1_n = 1'b0;
    repeat (8) @(negedge i_core_clk);
    run_cmd(1'b1, mux_addr, 4'h1);
    chk_byte("flagged lane", 8'h24, rbuf[0]);
    wr(mux_addr, 8'h05, 8'h00, 4'h1);
    chk_bit("flagged lane selected", 1'b1, down1);
    wr(mux_addr, 8'h04, 8'h00, 4'h1);
    chk_bit("down0 reselected", 1'b1, down0);
    alert1_n = 1'b1;
    alert0_n = 1'b1;
    wr(mux_addr ^ 7'h01, 8'h05, 8'h00, 4'h1);
    chk_bit("foreign address nack", 1'b1, last_nack);
    chk_bit("foreign write ignored", 1'b1, down0);
    addr_pin = 3'b101;
    repeat (8) @(negedge i_core_clk);
    wr({4'h5, 3'b101}, 8'h05, 8'h00, 4'h1);
    chk_bit("new pin address ack", 1'b0, last_nack);
    chk_bit("new pin address write", 1'b1, down1);
    test_done();
  end
endmodule
